//--- hw/tca_cfg.svh
`ifndef TCA_CFG_SVH
`define TCA_CFG_SVH
// Contract
// RL1: Power setting -10..20 dBm, 1 dB steps
// RL2: Ramp amplifier level gradually at programmed rate
// RL3: Direct mode passes pin bits straight through
// RL4: Payload preload only in standby, synth, transmit
// RL5: Pin functions limited per pin; input pin one
// RL6: Bit clock output, enabled automatically in transmit
// RL7: Sleep timer wakes periodically, 0.03125 ms steps
// RL8: Slow oscillator calibrated at power-up, then periodically
// RL9: Battery measured on every tune into synth/transmit; code measures only when tuning from sleep or standby
// RL10: Low battery halts; host commands sleep or standby
// RL11: Carrier = base + 2.5 kHz * step * channel
// RL12: Logic clocked from crystal or external reference
// RL13: Four-bit state codes reported
// RL14: Hop offset is full 16-bit unsigned product

// Timing
`define TCA_CLK_HZ 50000000
`define TCA_CAL_TIME_US 4000
`define TCA_CAL_CYC (`TCA_CAL_TIME_US * (`TCA_CLK_HZ / 1000000))
`define TCA_SLOW_HZ 32000
`define TCA_SLOW_DIV (`TCA_CLK_HZ / `TCA_SLOW_HZ)
`define TCA_RECAL_TICKS 32'd32000
`define TCA_BITCLK_DIV 16'd50
`define TCA_LINK_HALF 8

// Device register index (7-bit)
`define TCA_A_POWER 7'h00
`define TCA_A_RAMP 7'h01
`define TCA_A_CFG 7'h02
`define TCA_A_CMD 7'h03
`define TCA_A_THRESH 7'h04
`define TCA_A_BATT 7'h05
`define TCA_A_HOPSTEP 7'h06
`define TCA_A_HOPCHAN 7'h07
`define TCA_A_HOPLO 7'h08
`define TCA_A_HOPHI 7'h09
`define TCA_A_TXDATA 7'h0a
`define TCA_A_SLP0 7'h0c
`define TCA_A_STATE 7'h61

// Power field
`define TCA_PWR_MIN 8'hf6
`define TCA_PWR_MAX 8'h14
`define TCA_PWR_OFS 8'h0b
`define TCA_PWR_RST 8'h00

// Config fields
`define TCA_PIN_DIN 2'h0
`define TCA_PIN_IRQA 2'h1
`define TCA_PIN_IRQB 2'h2
`define TCA_PIN_BCLK 2'h3
`define TCA_CFG_SLPEN 6
`define TCA_CFG_HALT 7

// State command codes
`define TCA_CMD_SLEEP 8'h01
`define TCA_CMD_STBY 8'h02
`define TCA_CMD_TFS 8'h04
`define TCA_CMD_TX 8'h06

// Host Wishbone byte offsets
`define TCA_W_CMD 6'h00
`define TCA_W_ADDR 6'h04
`define TCA_W_WDATA 6'h08
`define TCA_W_RDATA 6'h0c
`define TCA_W_IRQSTAT 6'h10
`define TCA_W_IRQCLR 6'h14
`define TCA_W_IRQEN 6'h18
`define TCA_W_DIRECT 6'h1c
`define TCA_IRQ_DONE 0
`define TCA_IRQ_LINEA 1
`endif

//--- hw/tca_pkg.sv
package tca_pkg;
    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_SLEEP  = 6'b000010,
        ST_STBY   = 6'b000100,
        ST_TFS    = 6'b001000,
        ST_TX     = 6'b010000,
        ST_LOWVDD = 6'b100000
    } tca_dev_state_e;

    typedef enum logic [4:0] {
        HS_IDLE  = 5'b00001,
        HS_SETUP = 5'b00010,
        HS_HIGH  = 5'b00100,
        HS_LOW   = 5'b01000,
        HS_DONE  = 5'b10000
    } tca_host_state_e;

    typedef logic [3:0] tca_code_t;
endpackage : tca_pkg

//--- hw/tca_link_if.sv
`timescale 1ns/1ns
interface tca_link_if;
    logic       linkClk;
    logic       linkSel;
    logic       linkWe;
    logic [6:0] linkAddr;
    logic [7:0] linkWdata;
    logic [7:0] linkRdata;
    logic       gpOneDevOut;
    logic       gpOneDevOe;
    logic       gpOneHostOut;
    logic       gpOneHostOe;
    logic       gpOne;
    logic       gpTwo;
    logic       gpThree;

    // Undriven pin reads low, as with a weak pull-down
    assign gpOne = gpOneDevOe ? gpOneDevOut : (gpOneHostOe ? gpOneHostOut : 1'b0);

    modport dev (input linkClk, linkSel, linkWe, linkAddr, linkWdata, gpOne,
                 output linkRdata, gpOneDevOut, gpOneDevOe, gpTwo, gpThree);
    modport host (output linkClk, linkSel, linkWe, linkAddr, linkWdata, gpOneHostOut, gpOneHostOe,
                  input linkRdata, gpOne, gpTwo, gpThree);
endinterface : tca_link_if

//--- hw/tca_device.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ns
`include "tca_cfg.svh"
module tca_device #(
    parameter int CAL_CYC   = `TCA_CAL_CYC,
    parameter int SLOW_DIV  = `TCA_SLOW_DIV
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    tca_link_if.dev          link,
    input  wire logic [7:0]  batteryLevelIn,
    output logic [4:0]       paLevel,
    output logic             modData,
    output logic             modDataValid,
    output logic             modBitClk,
    output logic [15:0]      hopOffset,
    output logic [7:0]       pktByte,
    output logic             pktByteValid,
    output logic             calBusy,
    output logic [3:0]       stateCode
);
    typedef struct packed {
        tca_pkg::tca_dev_state_e st;
        logic [1:0]  clkS1;
        logic [1:0]  clkS2;
        logic        clkPrev;
        logic [16:0] busS1;
        logic [16:0] busS2;
        logic        pinS1;
        logic        pinS2;
        logic [7:0]  power;
        logic [7:0]  ramp;
        logic [7:0]  cfg;
        logic [7:0]  thresh;
        logic [7:0]  battery;
        logic [7:0]  hopStep;
        logic [7:0]  hopChan;
        logic [31:0] sleepTicks;
        logic [4:0]  pa;
        logic [6:0]  rampCnt;
        logic [31:0] calCnt;
        logic [15:0] slowDiv;
        logic [31:0] sleepCnt;
        logic [31:0] recalCnt;
        logic [15:0] bitDiv;
        logic        bitClk;
        logic        sysDiv;
        logic [7:0]  rdata;
        logic [7:0]  pkt;
        logic        pktV;
        logic        dat;
        logic        datV;
    } tca_dev_s;

    tca_dev_s r;
    tca_dev_s next_r;

    logic        linkRise;
    logic        wrEn;
    logic [6:0]  acc;
    logic [7:0]  wd;
    logic [4:0]  paTarget;
    logic        directMode;
    logic        slowTick;
    logic [7:0]  cmdVal;
    logic        tuneTo;

    // Decoded link strobes from the synchronised copies only
    assign linkRise   = r.clkS2[0] & ~r.clkPrev;
    assign acc        = r.busS2[15:9];
    assign wd         = r.busS2[8:1];
    assign wrEn       = linkRise & r.clkS2[1] & r.busS2[0];
    assign directMode = (r.cfg[1:0] == `TCA_PIN_DIN); // RL5
    assign cmdVal     = wrEn && acc == `TCA_A_CMD ? wd : 8'h00;
    assign tuneTo     = (cmdVal == `TCA_CMD_TFS || cmdVal == `TCA_CMD_TX)
                        && (r.st == tca_pkg::ST_SLEEP || r.st == tca_pkg::ST_STBY);
    assign paTarget   = (r.st == tca_pkg::ST_TX) ? 5'(r.power + `TCA_PWR_OFS) : 5'h00;
    assign slowTick   = (r.slowDiv == 16'(SLOW_DIV - 1));

    // Next-state logic for the whole device end
    always_comb begin
        next_r = r;
        next_r.clkS1   = {link.linkSel, link.linkClk};
        next_r.clkS2   = r.clkS1;
        next_r.clkPrev = r.clkS2[0];
        next_r.busS1   = {1'b0, link.linkAddr, link.linkWdata, link.linkWe};
        next_r.busS2   = r.busS1;
        next_r.pinS1   = link.gpOne;
        next_r.pinS2   = r.pinS1;
        next_r.pktV    = 1'b0;
        next_r.sysDiv  = ~r.sysDiv;
        next_r.slowDiv = slowTick ? 16'h0000 : r.slowDiv + 16'h0001;

        // Register writes over the link
        if (wrEn) begin
            unique case (acc)
                `TCA_A_POWER: begin
                    if ($signed(wd) < $signed(`TCA_PWR_MIN)) next_r.power = `TCA_PWR_MIN; // RL1
                    else if ($signed(wd) > $signed(`TCA_PWR_MAX)) next_r.power = `TCA_PWR_MAX; // RL1
                    else next_r.power = wd; // RL1
                end
                `TCA_A_RAMP:    next_r.ramp = wd;
                `TCA_A_CFG: begin
                    next_r.cfg = wd;
                    if (wd[3:2] == `TCA_PIN_BCLK) next_r.cfg[3:2] = `TCA_PIN_BCLK - 2'h1; // RL5
                    if (wd[5:4] == `TCA_PIN_BCLK) next_r.cfg[5:4] = `TCA_PIN_BCLK - 2'h1; // RL5
                end
                `TCA_A_THRESH:  next_r.thresh = wd;
                `TCA_A_HOPSTEP: next_r.hopStep = wd; // RL11
                `TCA_A_HOPCHAN: next_r.hopChan = wd; // RL11
                `TCA_A_TXDATA: begin
                    // Bytes offered in sleep or idle are dropped: the buffer is unpowered
                    if (r.st inside {tca_pkg::ST_STBY, tca_pkg::ST_TFS, tca_pkg::ST_TX}) begin
                        next_r.pkt  = wd; // RL4
                        next_r.pktV = 1'b1; // RL4
                    end
                end
                default: ;
            endcase
        end

        // Operating state sequence
        unique case (r.st)
            tca_pkg::ST_IDLE: begin
                next_r.calCnt = r.calCnt + 32'h1;
                if (r.calCnt >= 32'(CAL_CYC - 1)) begin // RL8
                    next_r.calCnt   = 32'h0;
                    next_r.recalCnt = 32'h0;
                    next_r.st       = tca_pkg::ST_SLEEP;
                end
            end
            tca_pkg::ST_SLEEP: begin
                if (slowTick && r.cfg[`TCA_CFG_SLPEN]) begin
                    next_r.sleepCnt = r.sleepCnt + 32'h1;
                    if (r.sleepCnt + 32'h1 >= r.sleepTicks) begin // RL7
                        next_r.sleepCnt = 32'h0;
                        next_r.st       = tca_pkg::ST_STBY; // RL7
                    end
                end
            end
            default: ;
        endcase

        // Periodic slow oscillator recalibration, counted in slow ticks
        if (r.st != tca_pkg::ST_IDLE && r.calCnt == 32'h0 && slowTick) begin
            next_r.recalCnt = r.recalCnt + 32'h1;
            if (r.recalCnt + 32'h1 >= `TCA_RECAL_TICKS) begin
                next_r.recalCnt = 32'h0;
                next_r.calCnt   = 32'(CAL_CYC - 1); // RL8
            end
        end else if (r.st != tca_pkg::ST_IDLE && r.calCnt != 32'h0) begin
            next_r.calCnt = r.calCnt - 32'h1; // RL8
        end

        // Host state commands; the low-supply hold only leaves to sleep or standby
        if (cmdVal == `TCA_CMD_SLEEP) begin
            next_r.st = tca_pkg::ST_SLEEP;
            next_r.sleepCnt = 32'h0;
        end else if (cmdVal == `TCA_CMD_STBY) begin
            next_r.st = tca_pkg::ST_STBY; // RL10
        end else if (r.st != tca_pkg::ST_LOWVDD && r.st != tca_pkg::ST_IDLE
                     && (cmdVal == `TCA_CMD_TFS || cmdVal == `TCA_CMD_TX)) begin
            next_r.st = (cmdVal == `TCA_CMD_TX) ? tca_pkg::ST_TX : tca_pkg::ST_TFS;
            if (tuneTo) begin
                next_r.battery = batteryLevelIn; // RL9
                if (r.cfg[`TCA_CFG_HALT] && batteryLevelIn < r.thresh) begin
                    next_r.st = tca_pkg::ST_LOWVDD; // RL10
                end
            end
        end

        // Amplifier level: stepped one code per rate period when ramping
        if (!r.ramp[7]) begin
            next_r.pa = paTarget;
            next_r.rampCnt = 7'h00;
        end else if (r.pa != paTarget) begin
            next_r.rampCnt = r.rampCnt + 7'h01;
            if (r.rampCnt >= r.ramp[6:0]) begin
                next_r.rampCnt = 7'h00;
                next_r.pa = (r.pa < paTarget) ? r.pa + 5'h01 : r.pa - 5'h01; // RL2
            end
        end

        // Bit clock runs only in transmit, restarting on each entry
        if (r.st == tca_pkg::ST_TX) begin
            next_r.bitDiv = r.bitDiv + 16'h0001;
            if (r.bitDiv >= `TCA_BITCLK_DIV - 16'h0001) begin
                next_r.bitDiv = 16'h0000;
                next_r.bitClk = ~r.bitClk; // RL6
            end
        end else begin
            next_r.bitDiv = 16'h0000;
            next_r.bitClk = 1'b0;
        end

        // Direct data sampled on the bit clock rising edge, no framing
        next_r.datV = 1'b0;
        if (r.st == tca_pkg::ST_TX && directMode && !r.bitClk
            && r.bitDiv >= `TCA_BITCLK_DIV - 16'h0001) begin
            next_r.dat  = r.pinS2; // RL3
            next_r.datV = 1'b1; // RL3
        end

        // Read data prepared from the held address
        unique case (acc)
            `TCA_A_POWER:   next_r.rdata = r.power;
            `TCA_A_RAMP:    next_r.rdata = r.ramp;
            `TCA_A_CFG:     next_r.rdata = r.cfg;
            `TCA_A_THRESH:  next_r.rdata = r.thresh;
            `TCA_A_BATT:    next_r.rdata = r.battery; // RL9
            `TCA_A_HOPSTEP: next_r.rdata = r.hopStep;
            `TCA_A_HOPCHAN: next_r.rdata = r.hopChan;
            `TCA_A_HOPLO:   next_r.rdata = hopOffset[7:0];
            `TCA_A_HOPHI:   next_r.rdata = hopOffset[15:8];
            `TCA_A_STATE:   next_r.rdata = {4'h0, stateCode}; // RL13
            default:        next_r.rdata = 8'h00;
        endcase

        // Sleep interval bytes, little endian over four indexes
        for (int b = 0; b < 4; b++) begin
            if (acc == `TCA_A_SLP0 + 7'(b)) begin
                next_r.rdata = r.sleepTicks[8*b +: 8];
                if (wrEn) next_r.sleepTicks[8*b +: 8] = wd; // RL7
            end
        end
    end

    // State register; clk is the crystal or the external reference in its place
    always_ff @(posedge clk or negedge rst_b) begin // RL12
        if (!rst_b) begin
            r <= '0;
            r.st <= tca_pkg::ST_IDLE;
            r.power <= `TCA_PWR_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Four-bit state report
    always_comb begin
        unique case (r.st)
            tca_pkg::ST_IDLE:   stateCode = 4'h0; // RL13
            tca_pkg::ST_SLEEP:  stateCode = 4'h1; // RL13
            tca_pkg::ST_STBY:   stateCode = 4'h2; // RL13
            tca_pkg::ST_TFS:    stateCode = 4'h4; // RL13
            tca_pkg::ST_TX:     stateCode = 4'h6; // RL13
            tca_pkg::ST_LOWVDD: stateCode = 4'h8; // RL10
            default:            stateCode = 4'hf;
        endcase
    end

    // Pin routing: only pin one may take the direct data input
    always_comb begin
        link.gpOneDevOe  = ~directMode; // RL5
        unique case (r.cfg[1:0])
            `TCA_PIN_IRQA: link.gpOneDevOut = (r.st == tca_pkg::ST_TX);
            `TCA_PIN_IRQB: link.gpOneDevOut = (r.st == tca_pkg::ST_LOWVDD);
            `TCA_PIN_BCLK: link.gpOneDevOut = r.bitClk; // RL6
            default:       link.gpOneDevOut = 1'b0;
        endcase
        unique case (r.cfg[3:2])
            `TCA_PIN_DIN:  link.gpTwo = (r.st == tca_pkg::ST_TX);
            `TCA_PIN_IRQA: link.gpTwo = (r.st == tca_pkg::ST_LOWVDD);
            default:       link.gpTwo = r.bitClk; // RL6
        endcase
        unique case (r.cfg[5:4])
            `TCA_PIN_DIN:  link.gpThree = r.sysDiv & (r.st != tca_pkg::ST_SLEEP);
            `TCA_PIN_IRQA: link.gpThree = (r.st == tca_pkg::ST_LOWVDD);
            default:       link.gpThree = r.bitClk; // RL6
        endcase
    end

    assign link.linkRdata = r.rdata;
    assign hopOffset      = r.hopStep * r.hopChan; // RL14
    assign paLevel        = r.pa;
    assign modData        = r.dat;
    assign modDataValid   = r.datV;
    assign modBitClk      = r.bitClk;
    assign pktByte        = r.pkt;
    assign pktByteValid   = r.pktV;
    assign calBusy        = (r.calCnt != 32'h0) | (r.st == tca_pkg::ST_IDLE);
endmodule : tca_device

//--- hw/tca_host.sv
`timescale 1ns/1ns
`include "tca_cfg.svh"
module tca_host #(
    parameter int LINK_HALF = `TCA_LINK_HALF
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    tca_link_if.host         link,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq
);
    typedef struct packed {
        tca_pkg::tca_host_state_e st;
        logic [15:0] cnt;
        logic        we;
        logic [6:0]  addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic [7:0]  rdS1;
        logic [7:0]  rdS2;
        logic        irqS1;
        logic        irqS2;
        logic        irqPrev;
        logic [1:0]  irqStat;
        logic [1:0]  irqEn;
        logic [1:0]  direct;
        logic        ack;
        logic [31:0] dout;
    } tca_host_s;

    tca_host_s r;
    tca_host_s next_r;
    logic      wbWr;
    logic      busy;
    logic [1:0] evt;

    assign wbWr = wb_cyc_i & wb_stb_i & wb_we_i & ~r.ack & wb_sel_i[0];
    assign busy = (r.st != tca_pkg::HS_IDLE);

    // Bus slave, link sequencer and event capture
    always_comb begin
        next_r = r;
        next_r.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        next_r.rdS1 = link.linkRdata;
        next_r.rdS2 = r.rdS1;
        next_r.irqS1 = link.gpTwo;
        next_r.irqS2 = r.irqS1;
        next_r.irqPrev = r.irqS2;
        evt = 2'b00;
        evt[`TCA_IRQ_LINEA] = r.irqS2 & ~r.irqPrev;

        // One link transfer: setup, clock high, clock low, capture
        next_r.cnt = r.cnt + 16'h0001;
        unique case (r.st)
            tca_pkg::HS_IDLE: next_r.cnt = 16'h0000;
            tca_pkg::HS_SETUP, tca_pkg::HS_HIGH, tca_pkg::HS_LOW: if (r.cnt >= 16'(LINK_HALF - 1)) begin
                next_r.st = tca_pkg::tca_host_state_e'(r.st << 1);
                next_r.cnt = 16'h0000;
            end
            tca_pkg::HS_DONE: begin
                next_r.rdata = r.rdS2;
                next_r.st = tca_pkg::HS_IDLE;
                evt[`TCA_IRQ_DONE] = 1'b1;
            end
            default: next_r.st = tca_pkg::HS_IDLE;
        endcase

        // Register writes; a start while busy is ignored
        if (wbWr) begin
            unique case (wb_adr_i)
                `TCA_W_CMD: if (!busy && wb_dat_i[0]) begin
                    next_r.we = wb_dat_i[1];
                    next_r.st = tca_pkg::HS_SETUP;
                    next_r.cnt = 16'h0000;
                end
                `TCA_W_ADDR:   if (!busy) next_r.addr = wb_dat_i[6:0];
                `TCA_W_WDATA:  if (!busy) next_r.wdata = wb_dat_i[7:0];
                `TCA_W_IRQCLR: next_r.irqStat = r.irqStat & ~wb_dat_i[1:0];
                `TCA_W_IRQEN:  next_r.irqEn = wb_dat_i[1:0];
                `TCA_W_DIRECT: next_r.direct = wb_dat_i[1:0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        next_r.irqStat = next_r.irqStat | evt;

        unique case (wb_adr_i)
            `TCA_W_CMD:     next_r.dout = {31'h0, busy};
            `TCA_W_ADDR:    next_r.dout = {25'h0, r.addr};
            `TCA_W_WDATA:   next_r.dout = {24'h0, r.wdata};
            `TCA_W_RDATA:   next_r.dout = {24'h0, r.rdata};
            `TCA_W_IRQSTAT: next_r.dout = {30'h0, r.irqStat};
            `TCA_W_IRQEN:   next_r.dout = {30'h0, r.irqEn};
            `TCA_W_DIRECT:  next_r.dout = {30'h0, r.direct};
            default:        next_r.dout = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.st <= tca_pkg::HS_IDLE;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // Link drive: the host makes the link clock by division
    assign link.linkClk      = (r.st == tca_pkg::HS_HIGH);
    assign link.linkSel      = r.st inside {tca_pkg::HS_SETUP, tca_pkg::HS_HIGH, tca_pkg::HS_LOW};
    assign link.linkWe       = r.we;
    assign link.linkAddr     = r.addr;
    assign link.linkWdata    = r.wdata;
    assign link.gpOneHostOut = r.direct[0]; // RL3
    assign link.gpOneHostOe  = r.direct[1];
    assign wb_ack_o          = r.ack;
    assign wb_dat_o          = r.dout;
    assign irq               = |(r.irqStat & r.irqEn);
endmodule : tca_host

//--- bench/tca_monitor.sv
`timescale 1ns/1ns
module tca_monitor #(
    parameter int LINK_HALF = 8
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       linkClk,
    input wire logic       linkSel,
    input wire logic       linkWe,
    input wire logic [6:0] linkAddr,
    input wire logic [7:0] linkWdata,
    input wire logic       gpOneDevOe,
    input wire logic       gpOneHostOe
);
    logic [7:0] selCnt;
    logic [7:0] hiCnt;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Cycles spent so far in the frame and in the clock-high phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            selCnt <= 8'h00;
            hiCnt  <= 8'h00;
        end else begin
            selCnt <= linkSel ? selCnt + 8'h01 : 8'h00;
            hiCnt  <= linkClk ? hiCnt + 8'h01 : 8'h00;
        end
    end
    // Setup phase holds the clock low so fields settle before the device samples
    sequence setupLow;
        linkSel && !linkClk;
    endsequence
    sequence clockHigh;
        linkSel && linkClk;
    endsequence
    a_setup_low: assert property ($rose(linkSel) |-> setupLow [*8] ##1 clockHigh)
        else $error("link setup phase wrong");
    a_clk_framed: assert property (linkClk |-> linkSel)
        else $error("link clock outside frame");
    a_clk_rise_time: assert property ($rose(linkClk) |-> selCnt == LINK_HALF)
        else $error("link clock rose at wrong cycle");
    a_clk_high_len: assert property ($fell(linkClk) |-> hiCnt == LINK_HALF && linkSel)
        else $error("link clock high phase wrong");
    a_frame_length: assert property ($fell(linkSel) |-> selCnt == 3 * LINK_HALF)
        else $error("link frame length wrong");
    a_fields_hold: assert property (linkSel && $past(linkSel) |-> $stable({linkWe, linkAddr, linkWdata}))
        else $error("link fields moved in frame");
    a_frame_gap: assert property ($fell(linkSel) |-> !linkSel [*2])
        else $error("link frames too close");
    a_pin_single: assert property (!(gpOneDevOe && gpOneHostOe))
        else $error("pin one driven by both ends");
endmodule : tca_monitor

//--- bench/test_tx_control_assist.sv
`timescale 1ns/1ns
`include "tca_cfg.svh"
module test_tx_control_assist;
    logic        clk, rst_b, ce, wbCyc, wbWe, wbAck, irq, modData, modDataValid, modBitClk, pktByteValid, calBusy;
    logic [5:0]  wbAdr;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [7:0]  battery, pktByte, q;
    logic [4:0]  paLevel;
    logic [15:0] hopOffset;
    logic [3:0]  stateCode;
    logic        prev;
    int          n_errors = 0, checks = 0, pktCount = 0, modCount = 0, i, k;
    logic [22:0] rows [8];
    tca_link_if link ();
    tca_device #(.CAL_CYC(20), .SLOW_DIV(4)) tca_device_inst (.clk, .rst_b, .ce, .link, .batteryLevelIn(battery),
        .paLevel, .modData, .modDataValid, .modBitClk, .hopOffset, .pktByte, .pktByteValid, .calBusy, .stateCode);
    tca_host tca_host_inst (.clk, .rst_b, .ce, .link, .wb_cyc_i(wbCyc), .wb_stb_i(wbCyc), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(4'h1), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq);
    tca_monitor tca_monitor_inst (.clk, .rst_b, .linkClk(link.linkClk),
        .linkSel(link.linkSel), .linkWe(link.linkWe), .linkAddr(link.linkAddr), .linkWdata(link.linkWdata),
        .gpOneDevOe(link.gpOneDevOe), .gpOneHostOe(link.gpOneHostOe));
    // Pulses stand one cycle, so count them at every edge
    always @(posedge clk) begin
        pktCount <= pktCount + int'(pktByteValid === 1'b1);
        modCount <= modCount + int'(modDataValid === 1'b1);
    end
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Classic cycle: hold everything until ack is sampled, then drop for one cycle
    task automatic wb(input logic we, input logic [5:0] adr, input logic [31:0] dat, output logic [31:0] r);
        int n = 0;
        wbCyc <= 1'b1;
        {wbWe, wbAdr, wbDatW} <= {we, adr, dat};
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        r = wbDatR;
        wbCyc <= 1'b0;
        @(posedge clk);
        if (n >= 50) begin
            check("wbAck", 0, 1);
            summarize();
        end
    endtask : wb
    // One link transfer; completion is polled from the sticky status bit
    task automatic dev(input logic we, input logic [6:0] a, input logic [7:0] d, output logic [7:0] r);
        logic [31:0] s;
        int n = 0;
        wb(1'b1, `TCA_W_ADDR, {25'h0, a}, s);
        wb(1'b1, `TCA_W_WDATA, {24'h0, d}, s);
        wb(1'b1, `TCA_W_CMD, {30'h0, we, 1'b1}, s);
        s = 32'h0;
        while (s[0] !== 1'b1 && n < 40) begin
            wb(1'b0, `TCA_W_IRQSTAT, 32'h0, s);
            n++;
        end
        wb(1'b1, `TCA_W_IRQCLR, 32'h1, s);
        wb(1'b0, `TCA_W_RDATA, 32'h0, s);
        r = s[7:0];
        if (n >= 40) begin
            check("linkDone", 0, 1);
            summarize();
        end
    endtask : dev
    task automatic waitState(input logic [3:0] code);
        int n = 0;
        while (stateCode !== code && n < 400) begin
            @(posedge clk);
            n++;
        end
        check("stateCode", stateCode, code);
    endtask : waitState
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst_b, wbCyc, wbWe, wbAdr, wbDatW} = '0;
        ce = 1'b1;
        battery = 8'hff;
        rows = '{{`TCA_A_POWER, 8'hf0, 8'hf6}, {`TCA_A_POWER, 8'h1e, 8'h14}, {`TCA_A_POWER, 8'h05, 8'h05},
                 {`TCA_A_HOPSTEP, 8'hc8, 8'hc8}, {`TCA_A_HOPCHAN, 8'hfa, 8'hfa}, {`TCA_A_HOPLO, 8'h00, 8'h50},
                 {`TCA_A_HOPHI, 8'h00, 8'hc3}, {`TCA_A_STATE, 8'h00, 8'h01}};
        repeat (3) @(posedge clk);
        check("resetState", stateCode, 4'h0);
        check("calBusy", calBusy, 1'b1);
        rst_b <= 1'b1;
        waitState(4'h1);
        // Register table: write, read back, compare
        for (i = 0; i < 8; i++) begin
            dev(1'b1, rows[i][22:16], rows[i][15:8], q);
            dev(1'b0, rows[i][22:16], 8'h00, q);
            check("devReg", q, rows[i][7:0]);
        end
        check("hopOffset", hopOffset, 16'hc350);
        wb(1'b0, 6'h20, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        // Interrupt raised, masked, cleared
        wb(1'b1, `TCA_W_IRQEN, 32'h1, rd);
        dev(1'b1, `TCA_A_THRESH, 8'h80, q);
        wb(1'b1, `TCA_W_CMD, 32'h1, rd);
        repeat (3 * 8 + 3) @(posedge clk);
        check("irqRaised", irq, 1'b1);
        wb(1'b1, `TCA_W_IRQEN, 32'h0, rd);
        check("irqMasked", irq, 1'b0);
        wb(1'b1, `TCA_W_IRQCLR, 32'h1, rd);
        wb(1'b0, `TCA_W_IRQSTAT, 32'h0, rd);
        check("irqClear", rd[0], 1'b0);
        // Direct mode on pin one, bit clock on pin two
        dev(1'b1, `TCA_A_CFG, 8'h08, q);
        check("pinOneOe", link.gpOneDevOe, 1'b0);
        wb(1'b1, `TCA_W_DIRECT, 32'h3, rd);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_TX, q);
        waitState(4'h6);
        repeat (100) @(posedge clk);
        check("paLevel", paLevel, 5'h10);
        k = 0;
        for (i = 0; i < 200; i++) begin
            prev = link.gpTwo;
            @(negedge clk);
            k += int'(link.gpTwo === 1'b1 && prev === 1'b0);
        end
        check("bitClkRises", k, 2);
        check("modDataHigh", modData, 1'b1);
        wb(1'b1, `TCA_W_DIRECT, 32'h2, rd);
        k = modCount;
        for (i = 0; i < 400 && modCount < k + 3; i++) @(posedge clk);
        check("modDataLow", modData, 1'b0);
        k = pktCount;
        dev(1'b1, `TCA_A_TXDATA, 8'ha5, q);
        for (i = 0; i < 100 && pktCount == k; i++) @(posedge clk);
        check("pktByte", pktByte, 8'ha5);
        // Ramped turn-on passes through intermediate levels
        dev(1'b1, `TCA_A_RAMP, 8'h83, q);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_SLEEP, q);
        waitState(4'h1);
        k = pktCount;
        dev(1'b1, `TCA_A_TXDATA, 8'h5a, q);
        repeat (50) @(posedge clk);
        check("pktDropped", pktCount, k);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_TX, q);
        waitState(4'h6);
        repeat (8) @(posedge clk);
        check("rampMid", paLevel > 5'h00 && paLevel < 5'h10, 1'b1);
        repeat (100) @(posedge clk);
        check("rampEnd", paLevel, 5'h10);
        // Low battery halt on tuning from sleep
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_SLEEP, q);
        dev(1'b1, `TCA_A_CFG, 8'h88, q);
        battery <= 8'h40;
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_TX, q);
        waitState(4'h8);
        dev(1'b0, `TCA_A_BATT, 8'h00, q);
        check("battery", q, 8'h40);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_TX, q);
        check("haltHeld", stateCode, 4'h8);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_STBY, q);
        waitState(4'h2);
        // Sleep timer wakes the device by itself
        dev(1'b1, `TCA_A_CFG, 8'h40, q);
        dev(1'b1, `TCA_A_SLP0, 8'h40, q);
        dev(1'b1, `TCA_A_CMD, `TCA_CMD_SLEEP, q);
        waitState(4'h1);
        waitState(4'h2);
        summarize();
    end
endmodule : test_tx_control_assist
